/* File: include/stcc_consts.svh */
// Offsets, field positions, reset values and timing counts of the serial control block
`ifndef STCC_CONSTS_SVH
`define STCC_CONSTS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define STCC_FRAME_BITS 5'd20
`define STCC_ADDR_LAST_BIT 5'd11
`define STCC_FRAME_LAST_BIT 5'd19
`define STCC_ROW_ZERO 8'h00

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define STCC_OFS_POWER_BYPASS 12'h103
`define STCC_OFS_DIAG_PLAYBACK 12'h104
`define STCC_OFS_POINTER_LOOPBACK 12'h105
`define STCC_OFS_PLAY_FIRST 12'h11f
`define STCC_OFS_PLAY_LAST 12'h13e
`define STCC_OFS_PTR_CAPTURE 12'h141
`define STCC_PLAY_B_INDEX 5'h10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STCC_RST_POWER_BYPASS 8'h00
`define STCC_RST_DIAG_PLAYBACK 8'h10
`define STCC_RST_POINTER_LOOPBACK 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STCC_BIT_READOUT 0
`define STCC_BIT_CHAIN_DISABLE 0
`define STCC_BIT_A_PDN 1
`define STCC_BIT_A_PDN_APPLY 2
`define STCC_BIT_B_PDN 3
`define STCC_BIT_B_PDN_APPLY 4
`define STCC_BIT_BYPASS 5
`define STCC_BIT_BYPASS_APPLY 6
`define STCC_BIT_A_PLAY 5
`define STCC_BIT_B_PLAY 6
`define STCC_BIT_NEAR_MASK 7
`define STCC_BIT_LOOPBACK 0
`define STCC_BIT_LOOPBACK_APPLY 1
`define STCC_BIT_PTR_CAPTURE 3

// ----------------------------------------------------------------
// Sample values and timing
// ----------------------------------------------------------------
`define STCC_MID_CODE 12'h800
`define STCC_NEAR_DISTANCE 2
`define STCC_SCLK_MAX_MHZ 40
`define STCC_SYS_CLK_MHZ 100

`endif

/* File: include/stcc_pkg.sv */
// Types shared by the serial control block
package stcc_pkg;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_ADDR,
    FR_WRITE,
    FR_READ
  } stcc_frame_e;

  typedef logic [7:0] stcc_byte_t;

endpackage

/* File: rtl/stcc_fifo.sv */
// Sample FIFO with valid and ready on both sides and exposed pointers
`timescale 1ns/10ps
module stcc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8,
  parameter int PTR_W = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [PTR_W:0] level,
  output logic [PTR_W-1:0] wr_ptr,
  output logic [PTR_W-1:0] rd_ptr
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic [PTR_W:0] count_next;
  logic in_ready_reg;
  logic out_valid_reg;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_reg;
  assign pop = out_valid_reg & out_ready;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Flags are registered from the next count so both ports stay flop-driven
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      count_reg <= count_next;
      in_ready_reg <= (count_next != (PTR_W + 1)'(DEPTH));
      out_valid_reg <= (count_next != '0);
    end
  end

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = count_reg;
  assign wr_ptr = wr_ptr_reg;
  assign rd_ptr = rd_ptr_reg;

endmodule

/* File: rtl/stcc_top.sv */
// Serial control port and the transmit chain controls it programs
`timescale 1ns/10ps
`include "stcc_consts.svh"

//Contract
//- A frame is 20 bits, twelve address bits then eight data bits.
//- Bits shift in only while select is low, on rising serial clock.
//- Any serial clock rate up to 40 MHz works if each high and low level lasts a system cycle.
//- Top four address bits pick the page, low eight the row.
//- Bit 0 of row zero in each page enables readout for that page.
//- In readout, addressed register other than row zero is not written but shifted out instead.
//- Samples enter an eight-deep FIFO, drained at clock over interpolation.
//- Chain disable powers down both channels and outputs mid-code.
//- Channel power-down needs its apply bit; a powered-down channel outputs mid-code.
//- Without features, all four power-down bits needed; with features, per channel.
//- Bypass with its apply bit passes inputs straight out, skipping the FIFO.
//- Playback mode cycles eight stored samples per channel to its output.
//- Enabled collision detection forces mid-code on two-away unless masked.
//- Pointer capture stores FIFO pointers each output tick, not during readout.
//- Loopback with its apply bit feeds the chain from the receive output.
module stcc_top
  import stcc_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int SAMPLE_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_select_n,
  input wire logic serial_clk,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic tx_data_in_clock,
  input wire logic [SAMPLE_W-1:0] tx_in_a,
  input wire logic [SAMPLE_W-1:0] tx_in_b,
  output logic tx_in_ready,
  input wire logic [SAMPLE_W-1:0] rx_out_a,
  input wire logic [SAMPLE_W-1:0] rx_out_b,
  input wire logic [1:0] interp_mode,
  input wire logic digital_feature_en,
  input wire logic collision_detect_en,
  output logic [SAMPLE_W-1:0] dac_a,
  output logic [SAMPLE_W-1:0] dac_b,
  output logic dac_tick
);

  localparam int PTR_W = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Serial frame capture
  // ----------------------------------------------------------------
  stcc_frame_e frame_state_reg;
  logic sclk_d_reg;
  logic [4:0] bit_cnt_reg;
  logic [18:0] shift_reg;
  stcc_byte_t out_shift_reg;
  logic serial_out_pin_reg;
  logic serial_out_oe_n_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic [19:0] frame_word;
  logic [11:0] frame_addr;
  logic [3:0] frame_page;
  logic [7:0] frame_row;
  logic [7:0] frame_data;
  logic addr_done;
  logic frame_done;
  logic commit_write;

  // Sampled at sys_clk, so one serial level must last a system cycle
  assign sclk_rise = serial_clk & ~sclk_d_reg & ~serial_select_n;
  assign sclk_fall = ~serial_clk & sclk_d_reg & ~serial_select_n;
  assign frame_word = {shift_reg, serial_in_pin};
  assign frame_addr = frame_word[19:8];
  assign frame_page = frame_addr[11:8];
  assign frame_row = frame_addr[7:0];
  assign frame_data = frame_word[7:0];
  assign addr_done = sclk_rise && (bit_cnt_reg == `STCC_ADDR_LAST_BIT);
  assign frame_done = sclk_rise && (bit_cnt_reg == `STCC_FRAME_LAST_BIT);
  assign commit_write = frame_done && (frame_state_reg == FR_WRITE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= serial_clk;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end else if (serial_select_n) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise && bit_cnt_reg != `STCC_FRAME_BITS) begin
      shift_reg <= frame_word[18:0];
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] readout_en_reg;
  stcc_byte_t power_bypass_reg;
  stcc_byte_t diag_playback_reg;
  stcc_byte_t pointer_loopback_reg;
  stcc_byte_t ptr_capture_reg;
  stcc_byte_t play_mem_reg [32];
  logic any_readout;

  assign any_readout = |readout_en_reg;

  function automatic logic is_play(input logic [11:0] a);
    is_play = (a >= `STCC_OFS_PLAY_FIRST) && (a <= `STCC_OFS_PLAY_LAST);
  endfunction

  function automatic logic [4:0] play_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - `STCC_OFS_PLAY_FIRST;
    play_index = d[4:0];
  endfunction

  function automatic stcc_byte_t read_byte(input logic [11:0] a);
    read_byte = 8'h00;
    if (a[7:0] == `STCC_ROW_ZERO) begin
      read_byte = {7'h00, readout_en_reg[a[11:8]]};
    end else if (is_play(a)) begin
      read_byte = play_mem_reg[play_index(a)];
    end else begin
      case (a)
        `STCC_OFS_POWER_BYPASS: read_byte = power_bypass_reg;
        `STCC_OFS_DIAG_PLAYBACK: read_byte = diag_playback_reg;
        `STCC_OFS_POINTER_LOOPBACK: read_byte = pointer_loopback_reg;
        `STCC_OFS_PTR_CAPTURE: read_byte = ptr_capture_reg;
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // Row zero stays writable in readout, otherwise readout could never be left
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_state_reg <= FR_IDLE;
    end else if (serial_select_n) begin
      frame_state_reg <= FR_IDLE;
    end else begin
      case (frame_state_reg)
        FR_IDLE: begin
          if (sclk_rise) begin
            frame_state_reg <= FR_ADDR;
          end
        end
        FR_ADDR: begin
          if (addr_done) begin
            if (readout_en_reg[frame_word[11:8]] && frame_word[7:0] != `STCC_ROW_ZERO) begin
              frame_state_reg <= FR_READ;
            end else begin
              frame_state_reg <= FR_WRITE;
            end
          end
        end
        FR_WRITE: frame_state_reg <= FR_WRITE;
        FR_READ: frame_state_reg <= FR_READ;
        default: frame_state_reg <= FR_IDLE;
      endcase
    end
  end

  // Readback byte leaves on falling edges so the host samples it on rising ones
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_shift_reg <= 8'h00;
      serial_out_pin_reg <= 1'b0;
      serial_out_oe_n_reg <= 1'b1;
    end else begin
      serial_out_oe_n_reg <= ~(frame_state_reg == FR_READ);
      if (addr_done) begin
        out_shift_reg <= read_byte(frame_word[11:0]);
      end else if (sclk_fall && frame_state_reg == FR_READ) begin
        serial_out_pin_reg <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      readout_en_reg <= '0;
    end else if (commit_write && frame_row == `STCC_ROW_ZERO) begin
      readout_en_reg[frame_page] <= frame_data[`STCC_BIT_READOUT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      power_bypass_reg <= `STCC_RST_POWER_BYPASS;
      diag_playback_reg <= `STCC_RST_DIAG_PLAYBACK;
      pointer_loopback_reg <= `STCC_RST_POINTER_LOOPBACK;
    end else if (commit_write) begin
      case (frame_addr)
        `STCC_OFS_POWER_BYPASS: power_bypass_reg <= frame_data;
        `STCC_OFS_DIAG_PLAYBACK: diag_playback_reg <= frame_data;
        `STCC_OFS_POINTER_LOOPBACK: pointer_loopback_reg <= frame_data;
        default: power_bypass_reg <= power_bypass_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        play_mem_reg[i] <= 8'h00;
      end
    end else if (commit_write && is_play(frame_addr)) begin
      play_mem_reg[play_index(frame_addr)] <= frame_data;
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  logic chain_disable;
  logic chan_a_powerdown;
  logic chan_a_powerdown_apply;
  logic chan_b_powerdown;
  logic chan_b_powerdown_apply;
  logic chain_bypass;
  logic chan_a_playback_en;
  logic chan_b_playback_en;
  logic near_collision_mask;
  logic pointer_capture_en;
  logic loopback_en;
  logic chan_a_off;
  logic chan_b_off;
  logic all_pdn;

  assign chain_disable = power_bypass_reg[`STCC_BIT_CHAIN_DISABLE];
  assign chan_a_powerdown = power_bypass_reg[`STCC_BIT_A_PDN];
  assign chan_a_powerdown_apply = power_bypass_reg[`STCC_BIT_A_PDN_APPLY];
  assign chan_b_powerdown = power_bypass_reg[`STCC_BIT_B_PDN];
  assign chan_b_powerdown_apply = power_bypass_reg[`STCC_BIT_B_PDN_APPLY];
  assign chain_bypass = power_bypass_reg[`STCC_BIT_BYPASS]
    & power_bypass_reg[`STCC_BIT_BYPASS_APPLY];
  assign chan_a_playback_en = diag_playback_reg[`STCC_BIT_A_PLAY];
  assign chan_b_playback_en = diag_playback_reg[`STCC_BIT_B_PLAY];
  assign near_collision_mask = diag_playback_reg[`STCC_BIT_NEAR_MASK];
  assign pointer_capture_en = pointer_loopback_reg[`STCC_BIT_PTR_CAPTURE];
  assign loopback_en = pointer_loopback_reg[`STCC_BIT_LOOPBACK]
    & pointer_loopback_reg[`STCC_BIT_LOOPBACK_APPLY];

  assign all_pdn = chan_a_powerdown & chan_a_powerdown_apply
    & chan_b_powerdown & chan_b_powerdown_apply;
  assign chan_a_off = chain_disable | (digital_feature_en
    ? (chan_a_powerdown & chan_a_powerdown_apply) : all_pdn);
  assign chan_b_off = chain_disable | (digital_feature_en
    ? (chan_b_powerdown & chan_b_powerdown_apply) : all_pdn);

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  logic [1:0] div_cnt_reg;
  logic [1:0] div_last;
  logic tick;
  logic [2:0] play_idx_reg;
  logic [2*SAMPLE_W-1:0] src_word;
  logic fifo_out_valid;
  logic [2*SAMPLE_W-1:0] fifo_out_data;
  logic [PTR_W:0] fifo_level;
  logic [PTR_W-1:0] fifo_wr_ptr;
  logic [PTR_W-1:0] fifo_rd_ptr;
  logic near_collide;
  logic [SAMPLE_W-1:0] dac_a_reg;
  logic [SAMPLE_W-1:0] dac_b_reg;
  logic dac_tick_reg;

  function automatic logic [1:0] divide_last(input logic [1:0] mode);
    case (mode)
      2'h0: divide_last = 2'h0;
      2'h1: divide_last = 2'h1;
      default: divide_last = 2'h3;
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] play_sample(input logic [4:0] base,
                                                      input logic [2:0] k);
    logic [4:0] lo;
    lo = base + {1'b0, k, 1'b0};
    play_sample = SAMPLE_W'({play_mem_reg[lo + 5'd1][3:0], play_mem_reg[lo]});
  endfunction

  assign div_last = divide_last(interp_mode);
  assign tick = (div_cnt_reg == div_last);
  assign src_word = loopback_en ? {rx_out_a, rx_out_b} : {tx_in_a, tx_in_b};
  assign near_collide = collision_detect_en & ~near_collision_mask
    & ((fifo_level == (PTR_W + 1)'(`STCC_NEAR_DISTANCE))
    | (fifo_level == (PTR_W + 1)'(DEPTH - `STCC_NEAR_DISTANCE)));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 2'h0;
    end else if (tick) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      play_idx_reg <= 3'h0;
    end else if (tick) begin
      play_idx_reg <= play_idx_reg + 3'h1;
    end
  end

  // Write side is the data input clock strobe, read side the divided tick
  stcc_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(tx_data_in_clock & ~chain_bypass),
    .in_ready(tx_in_ready),
    .in_data(src_word),
    .out_valid(fifo_out_valid),
    .out_ready(tick),
    .out_data(fifo_out_data),
    .level(fifo_level),
    .wr_ptr(fifo_wr_ptr),
    .rd_ptr(fifo_rd_ptr)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_capture_reg <= 8'h00;
    end else if (tick && pointer_capture_en && !any_readout) begin
      ptr_capture_reg <= 8'({fifo_wr_ptr, 1'b0, fifo_rd_ptr});
    end
  end

  // An empty FIFO yields mid-code rather than repeating stale data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_a_reg <= `STCC_MID_CODE;
      dac_b_reg <= `STCC_MID_CODE;
      dac_tick_reg <= 1'b0;
    end else if (chain_bypass && !chain_disable) begin
      dac_tick_reg <= tx_data_in_clock;
      if (tx_data_in_clock) begin
        dac_a_reg <= chan_a_off ? `STCC_MID_CODE : src_word[2*SAMPLE_W-1:SAMPLE_W];
        dac_b_reg <= chan_b_off ? `STCC_MID_CODE : src_word[SAMPLE_W-1:0];
      end
    end else begin
      dac_tick_reg <= tick;
      if (tick) begin
        if (chan_a_off || near_collide) begin
          dac_a_reg <= `STCC_MID_CODE;
        end else if (chan_a_playback_en) begin
          dac_a_reg <= play_sample(5'h00, play_idx_reg);
        end else begin
          dac_a_reg <= fifo_out_valid ? fifo_out_data[2*SAMPLE_W-1:SAMPLE_W] : `STCC_MID_CODE;
        end
        if (chan_b_off || near_collide) begin
          dac_b_reg <= `STCC_MID_CODE;
        end else if (chan_b_playback_en) begin
          dac_b_reg <= play_sample(`STCC_PLAY_B_INDEX, play_idx_reg);
        end else begin
          dac_b_reg <= fifo_out_valid ? fifo_out_data[SAMPLE_W-1:0] : `STCC_MID_CODE;
        end
      end
    end
  end

  assign serial_out_pin = serial_out_pin_reg;
  assign serial_out_oe_n = serial_out_oe_n_reg;
  assign dac_a = dac_a_reg;
  assign dac_b = dac_b_reg;
  assign dac_tick = dac_tick_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_write_bit;
    frame_done && frame_state_reg == FR_WRITE;
  endsequence

  // Divide by four held through the whole gap, so a mode change never trips it
  sequence s_quarter_gap;
    tick && interp_mode[1] ##1 interp_mode[1] [*4];
  endsequence

  frame_len_a: assert property (s_last_write_bit ##0 frame_addr == `STCC_OFS_POWER_BYPASS
    |=> power_bypass_reg == $past(frame_data, 1))
    else $error("power register not loaded from frame data");
  select_gate_a: assert property (serial_select_n |=> bit_cnt_reg == 5'd0)
    else $error("bit count not cleared while deselected");
  edge_only_a: assert property (!sclk_rise |=> $stable(bit_cnt_reg) || bit_cnt_reg == 5'd0)
    else $error("bit count moved without a rising serial edge");
  readout_bit_a: assert property (s_last_write_bit ##0 frame_row == `STCC_ROW_ZERO
    |=> readout_en_reg[$past(frame_page)] == $past(frame_data[0]))
    else $error("readout enable not taken from row zero");
  readout_hold_a: assert property (frame_done && frame_state_reg == FR_READ
    |=> $stable(power_bypass_reg) && $stable(diag_playback_reg) && $stable(pointer_loopback_reg))
    else $error("register changed during readout frame");
  pace_four_a: assert property (s_quarter_gap
    |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
    else $error("divide by four pacing broken");
  disable_mid_a: assert property (chain_disable && tick |=>
    dac_a == `STCC_MID_CODE && dac_b == `STCC_MID_CODE)
    else $error("disabled chain not at mid-code");
  bypass_pass_a: assert property (chain_bypass && !chain_disable && !chan_a_off
    && tx_data_in_clock |=> dac_a == $past(src_word[2*SAMPLE_W-1:SAMPLE_W]))
    else $error("bypass sample not passed through");
  ptr_freeze_a: assert property (any_readout |=> $stable(ptr_capture_reg))
    else $error("pointer capture updated during readout");

endmodule

/* File: test/stcc_host_model.sv */
// Host controller model driving the serial programming port
`timescale 1ns/10ps
module stcc_host_model (
  input wire logic sys_clk,
  output logic serial_select_n,
  output logic serial_clk,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  initial begin
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in_pin = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // Low level held 4 cycles so the oversampled falling edge lands first
  task automatic frame(input logic [19:0] f, input int nbits);
    logic rd;
    rd = 1'b0;
    @(posedge sys_clk) serial_select_n <= 1'b0;
    for (int i = 19; i >= 20 - nbits; i--) begin
      serial_in_pin <= f[i];
      repeat (4) @(posedge sys_clk);
      if (i < 8 && serial_out_oe_n === 1'b0) begin
        rd = 1'b1;
        rd_byte <= {rd_byte[6:0], serial_out_pin};
      end
      serial_clk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      serial_clk <= 1'b0;
    end
    serial_select_n <= 1'b1;
    serial_in_pin <= ~serial_in_pin;
    rd_done <= rd;
    @(posedge sys_clk) rd_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

/* File: test/stcc_top_test.sv */
// Self-checking bench for the serial control block
`timescale 1ns/10ps
module stcc_top_test
  import stcc_pkg::*;
;
  logic sys_clk, rst_n, sel_n, sclk, sdi, sdo, oe_n, strobe, ready, rd_done, tick;
  logic feat, coll, pa, pb, lb, byp, full;
  logic [1:0] interp;
  logic [11:0] ta, tb, ra, rb, da, db, p;
  logic [7:0] rd_byte, r;
  logic [23:0] dq[$];
  stcc_byte_t rq[$];
  logic [31:0] lfsr;
  int fails, tests_run, cyc;
  stcc_top u_stcc_top (.sys_clk(sys_clk), .rst_n(rst_n), .serial_select_n(sel_n),
    .serial_clk(sclk), .serial_in_pin(sdi), .serial_out_pin(sdo), .serial_out_oe_n(oe_n),
    .tx_data_in_clock(strobe), .tx_in_a(ta), .tx_in_b(tb), .tx_in_ready(ready),
    .rx_out_a(ra), .rx_out_b(rb), .interp_mode(interp), .digital_feature_en(feat),
    .collision_detect_en(coll), .dac_a(da), .dac_b(db), .dac_tick(tick));
  stcc_host_model u_stcc_host_model (.sys_clk(sys_clk), .serial_select_n(sel_n),
    .serial_clk(sclk), .serial_in_pin(sdi), .serial_out_pin(sdo),
    .serial_out_oe_n(oe_n), .rd_done(rd_done), .rd_byte(rd_byte));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk_byte(input string n, input stcc_byte_t e, input stcc_byte_t s);
    tests_run++;
    if (e !== s) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_pair(input string n, input logic [23:0] e, input logic [23:0] s);
    tests_run++;
    if (e !== s) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("counts tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Mid-code ticks come from an empty FIFO or the disabled chain, so they carry no note
  always @(posedge sys_clk) begin
    if (rd_done) chk_byte("readback", rq.pop_front(), rd_byte);
    if (tick && dq.size() > 0 && {da, db} !== {2{12'h800}}) begin
      chk_pair("dac", dq.pop_front(), {da, db});
    end
    cyc++;
    if (cyc > 40000) begin
      fails++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Driving
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge sys_clk) begin
    if (strobe && (ready || byp) && !(pa && pb)) begin
      dq.push_back({pa ? 12'h800 : (lb ? ra : ta), pb ? 12'h800 : (lb ? rb : tb)});
    end
  end
  task automatic wr(input logic [11:0] a, input stcc_byte_t d);
    u_stcc_host_model.frame({a, d}, 20);
  endtask
  task automatic rd(input logic [11:0] a, input stcc_byte_t e);
    rq.push_back(e);
    lfsr = nxt(lfsr);
    wr({a[11:8], 8'h00}, 8'h01);
    wr(a, lfsr[7:0]);
    wr({a[11:8], 8'h00}, 8'h00);
  endtask
  task automatic send(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      lfsr = nxt(lfsr);
      if (ready !== 1'b1) full = 1'b1;
      strobe <= 1'b1;
      ta <= lfsr[11:0] | 12'h001;
      tb <= lfsr[23:12] | 12'h001;
      ra <= lfsr[31:20] | 12'h001;
      rb <= {lfsr[3:0], lfsr[31:24]} | 12'h001;
      repeat (gap) @(posedge sys_clk) strobe <= 1'b0;
    end
    @(posedge sys_clk) strobe <= 1'b0;
    repeat (30) @(posedge sys_clk);
  endtask
  initial begin
    {rst_n, strobe, pa, pb, lb, byp, full, feat} = 8'h01;
    {ta, tb, ra, rb} = 48'h0;
    interp = 2'd2;
    coll = 1'b1;
    lfsr = 32'h5cdbc25b;
    {fails, tests_run, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(12'h103, 8'h00);
    rd(12'h104, 8'h10);
    rd(12'h105, 8'h00);
    $display("done reset values");
    r = lfsr[7:0];
    wr(12'h105, r);
    rd(12'h105, r);
    rd(12'h105, r);
    u_stcc_host_model.frame({12'h105, ~r}, 16);
    rd(12'h105, r);
    wr(12'h105, 8'h00);
    $display("done register access");
    wr(12'h104, 8'h80);
    send(14, 0);
    repeat (30) @(posedge sys_clk);
    chk_byte("refused", 8'h01, {7'h0, full});
    chk_byte("drained", 8'h00, 8'(dq.size()));
    $display("done fifo");
    wr(12'h105, 8'h03);
    lb = 1'b1;
    send(4, 5);
    lb = 1'b0;
    wr(12'h105, 8'h00);
    $display("done loopback");
    wr(12'h103, 8'h06);
    pa = 1'b1;
    send(3, 5);
    pa = 1'b0;
    feat <= 1'b0;
    send(3, 5);
    $display("done power down");
    // Low bytes only, so sample k reads back as 0x048 plus k
    for (int k = 0; k < 8; k++) wr(12'h11f + 12'(2 * k), 8'h48 + 8'(k));
    wr(12'h104, 8'ha0);
    p = 12'h000;
    repeat (40) begin
      @(posedge sys_clk);
      if (tick) begin
        if (p != 12'h000) chk_pair("playback", {12'h048 | ((p + 12'h001) % 12'h008), 12'h800}, {da, db});
        p = da;
      end
    end
    wr(12'h104, 8'h80);
    $display("done playback");
    interp <= 2'd0;
    wr(12'h103, 8'h60);
    byp = 1'b1;
    send(4, 3);
    wr(12'h103, 8'h61);
    {pa, pb} = 2'b11;
    send(1, 3);
    chk_pair("disabled", {2{12'h800}}, {da, db});
    $display("done bypass and disable");
    wrap_up();
  end
endmodule
